// ---- verilog/prs_map.svh ----
// Register offsets, field positions, reset values and timing counts of the run sequencer
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
// Register byte offsets
`define PRS_CTRL_OFS 8'h00
`define PRS_PREREG_FREQ_OFS 8'h04
`define PRS_PREREG_EXIT_OFS 8'h08
`define PRS_PREREG_DELAY_OFS 8'h0c
`define PRS_SLEEP_DELAY_OFS 8'h10
`define PRS_SLEEP_FREQ_OFS 8'h14
`define PRS_WAKE_LEVEL_OFS 8'h18
`define PRS_WAKE_SEL_OFS 8'h1c
`define PRS_STATUS_OFS 8'h20
`define PRS_IRQ_STAT_OFS 8'h24
`define PRS_IRQ_CLR_OFS 8'h28
`define PRS_IRQ_EN_OFS 8'h2c
// Control fields
`define PRS_CTRL_RUN_BIT 0
`define PRS_CTRL_PREREG_EN_BIT 1
`define PRS_CTRL_FAULT_CLR_BIT 2
`define PRS_CTRL_BYPASS_FUNC_LSB 8
// Bypass function code
`define PRS_BYPASS_FUNC_CODE 8'h17
// Reset values
`define PRS_CTRL_RST 32'h0000_0000
`define PRS_PARAM_RST 16'h0000
`define PRS_WAKE_SEL_RST 3'h0
// Timing: one tick of the delay counters is 1 ms
`define PRS_TICK_NS 1000000
`define PRS_CLK_NS 4
`define PRS_TICK_CYC (`PRS_TICK_NS / `PRS_CLK_NS)
// Interrupt bit positions
`define PRS_IRQ_FAULT_BIT 0
`define PRS_IRQ_SLEEP_BIT 1
`define PRS_IRQ_WAKE_BIT 2
`define PRS_IRQ_W 3
`endif

// ---- verilog/prs_pkg.sv ----
// Types shared by the run sequencer
package prs_pkg;
   typedef enum logic [2:0] {PRS_IDLE, PRS_PREREG, PRS_PID, PRS_OPEN, PRS_SLEEP, PRS_FAULT} prs_state_t;
   typedef logic [15:0] prs_word_t;
   typedef logic [2:0] prs_wake_t;
endpackage

// ---- verilog/prs_hold_timer.sv ----
// Counter that reports when a condition has held for a set number of millisecond ticks
`timescale 1ns/100ps
module prs_hold_timer
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Control
   input wire logic tick,
   input wire logic cond,
   input wire logic [15:0] limit,
   // Result
   output logic expired
);
   logic [15:0] cnt_r;

   // Count ticks while the condition holds, restart when it drops
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         cnt_r <= 16'h0000;
      else if (!cond)
         cnt_r <= 16'h0000;
      else if (tick && cnt_r != 16'hffff)
         cnt_r <= cnt_r + 16'h0001;
   end

   assign expired = cond && (cnt_r >= limit);
endmodule

// ---- verilog/prs_top.sv ----
// Run sequencer around a process regulator: pre-regulation, sleep/wake and bypass
// Functional notes
// - On run with pre-regulation on, ramp to the pre-regulation frequency without regulation.
// - In pre-regulation, hand over to the regulator once feedback exceeds the exit level.
// - With a nonzero start delay, feedback at or below the exit level that long raises a fault and blocks output.
// - Output below the sleep frequency for the sleep delay stops output and enters sleep.
// - In sleep, output stays stopped until the selected wake condition holds.
// - Wake mode 0 wakes when feedback falls below the wake level.
// - Wake mode 1 wakes when feedback rises above the wake level.
// - Wake mode 2 wakes when reference minus feedback exceeds the wake level.
// - An active input set to the bypass function halts regulation and runs open loop.
// - When the bypass input goes inactive, regulation restarts.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "prs_map.svh"
module prs_top
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   // AXI4-Lite write address
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   // AXI4-Lite write data
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read address
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   // AXI4-Lite read data
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // Process signals
   input wire logic [4:0] MFI_ACTIVE,
   input wire logic [39:0] MFI_FUNC,
   input wire prs_pkg::prs_word_t FEEDBACK,
   input wire prs_pkg::prs_word_t REFERENCE,
   input wire prs_pkg::prs_word_t OUT_FREQ,
   // Output stage
   output prs_pkg::prs_word_t FREQ_TARGET,
   output logic PID_ACTIVE,
   output logic OUTPUT_ENABLE,
   output logic STARTUP_FEEDBACK_FAULT,
   output logic SLEEPING,
   // Interrupt
   output logic IRQ
);
   import prs_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   prs_state_t state_r;
   prs_state_t state_nxt;
   logic [31:0] ctrl_r;
   prs_word_t prereg_frequency_r;
   prs_word_t prereg_exit_level_r;
   prs_word_t prereg_fail_delay_r;
   prs_word_t sleep_delay_time_r;
   prs_word_t sleep_frequency_r;
   prs_word_t wake_level_r;
   prs_wake_t wake_condition_select_r;
   logic [`PRS_IRQ_W-1:0] irq_stat_r;
   logic [`PRS_IRQ_W-1:0] irq_en_r;
   logic [`PRS_IRQ_W-1:0] irq_clr;
   logic [`PRS_IRQ_W-1:0] irq_set;
   logic [17:0] tick_cnt_r;
   logic tick;
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_fire;
   logic [31:0] wr_mask;
   logic [31:0] rd_val;
   logic rd_ok;
   logic run;
   logic bypass;
   logic wake;
   logic fb_low;
   logic low_freq;
   logic fail_exp;
   logic sleep_exp;
   logic [16:0] err_diff;

   // ------------------------------------------------------------
   // Millisecond tick
   // ------------------------------------------------------------
   // Divide the system clock down to 1 ms
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
         tick_cnt_r <= 18'h00000;
      else if (tick)
         tick_cnt_r <= 18'h00000;
      else
         tick_cnt_r <= tick_cnt_r + 18'h00001;
   end

   assign tick = (tick_cnt_r == 18'((`PRS_TICK_CYC) - 1));

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   // Capture address and data in either order
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_held_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
         end
         else if (wr_fire)
            aw_held_r <= 1'b0;
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_held_r <= 1'b1;
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB;
         end
         else if (wr_fire)
            w_held_r <= 1'b0;
      end
   end

   assign wr_fire = aw_held_r && w_held_r && !S_AXI_BVALID;
   assign wr_mask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

   // Ready while the slot is empty; response after both halves
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= 2'h0;
      end
      else
      begin
         S_AXI_AWREADY <= !aw_held_r && !(S_AXI_AWVALID && S_AXI_AWREADY);
         S_AXI_WREADY <= !w_held_r && !(S_AXI_WVALID && S_AXI_WREADY);
         if (wr_fire)
         begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (aw_addr_r <= `PRS_IRQ_EN_OFS && aw_addr_r[1:0] == 2'h0 &&
                            aw_addr_r != `PRS_STATUS_OFS && aw_addr_r != `PRS_IRQ_STAT_OFS) ? 2'h0 : 2'h2;
         end
         else if (S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Parameter registers
   // ------------------------------------------------------------
   // Byte-masked register writes
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         ctrl_r <= `PRS_CTRL_RST;
         prereg_frequency_r <= `PRS_PARAM_RST;
         prereg_exit_level_r <= `PRS_PARAM_RST;
         prereg_fail_delay_r <= `PRS_PARAM_RST;
         sleep_delay_time_r <= `PRS_PARAM_RST;
         sleep_frequency_r <= `PRS_PARAM_RST;
         wake_level_r <= `PRS_PARAM_RST;
         wake_condition_select_r <= `PRS_WAKE_SEL_RST;
         irq_en_r <= '0;
      end
      else
      begin
         ctrl_r[`PRS_CTRL_FAULT_CLR_BIT] <= 1'b0; // Self-clearing
         if (wr_fire)
         begin
            case (aw_addr_r)
               `PRS_CTRL_OFS: ctrl_r <= (ctrl_r & ~wr_mask) | (w_data_r & wr_mask);
               `PRS_PREREG_FREQ_OFS: prereg_frequency_r <= (prereg_frequency_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]);
               `PRS_PREREG_EXIT_OFS: prereg_exit_level_r <= (prereg_exit_level_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]);
               `PRS_PREREG_DELAY_OFS: prereg_fail_delay_r <= (prereg_fail_delay_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]);
               `PRS_SLEEP_DELAY_OFS: sleep_delay_time_r <= (sleep_delay_time_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]);
               `PRS_SLEEP_FREQ_OFS: sleep_frequency_r <= (sleep_frequency_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]);
               `PRS_WAKE_LEVEL_OFS: wake_level_r <= (wake_level_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]);
               `PRS_WAKE_SEL_OFS:
               begin
                  if (w_strb_r[0])
                     wake_condition_select_r <= w_data_r[2:0];
               end
               `PRS_IRQ_EN_OFS:
               begin
                  if (w_strb_r[0])
                     irq_en_r <= w_data_r[`PRS_IRQ_W-1:0];
               end
               default: ;
            endcase
         end
      end
   end

   assign irq_clr = (wr_fire && aw_addr_r == `PRS_IRQ_CLR_OFS && w_strb_r[0]) ? w_data_r[`PRS_IRQ_W-1:0] : '0;

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   // Read multiplexer
   always_comb
   begin
      rd_ok = 1'b1;
      rd_val = 32'h0000_0000;
      case (S_AXI_ARADDR)
         `PRS_CTRL_OFS: rd_val = ctrl_r;
         `PRS_PREREG_FREQ_OFS: rd_val = {16'h0000, prereg_frequency_r};
         `PRS_PREREG_EXIT_OFS: rd_val = {16'h0000, prereg_exit_level_r};
         `PRS_PREREG_DELAY_OFS: rd_val = {16'h0000, prereg_fail_delay_r};
         `PRS_SLEEP_DELAY_OFS: rd_val = {16'h0000, sleep_delay_time_r};
         `PRS_SLEEP_FREQ_OFS: rd_val = {16'h0000, sleep_frequency_r};
         `PRS_WAKE_LEVEL_OFS: rd_val = {16'h0000, wake_level_r};
         `PRS_WAKE_SEL_OFS: rd_val = {29'h0000000, wake_condition_select_r};
         `PRS_STATUS_OFS: rd_val = {29'h0000000, state_r};
         `PRS_IRQ_STAT_OFS: rd_val = {29'h0000000, irq_stat_r};
         `PRS_IRQ_CLR_OFS: rd_val = 32'h0000_0000;
         `PRS_IRQ_EN_OFS: rd_val = {29'h0000000, irq_en_r};
         default: rd_ok = 1'b0;
      endcase
   end

   // One read at a time, answered the cycle after the address
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= 2'h0;
      end
      else
      begin
         S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
         if (S_AXI_ARVALID && S_AXI_ARREADY)
         begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_val;
            S_AXI_RRESP <= rd_ok ? 2'h0 : 2'h2;
         end
         else if (S_AXI_RREADY)
            S_AXI_RVALID <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Conditions
   // ------------------------------------------------------------
   // Bypass when any input mapped to the bypass function is on
   always_comb
   begin
      bypass = 1'b0;
      for (int i = 0; i < 5; i++)
         if (MFI_ACTIVE[i] && MFI_FUNC[i*8 +: 8] == `PRS_BYPASS_FUNC_CODE)
            bypass = 1'b1;
   end

   assign run = ctrl_r[`PRS_CTRL_RUN_BIT];
   assign fb_low = FEEDBACK <= prereg_exit_level_r;
   assign low_freq = OUT_FREQ < sleep_frequency_r;
   assign err_diff = {1'b0, REFERENCE} - {1'b0, FEEDBACK};

   // Wake condition by mode
   always_comb
   begin
      case (wake_condition_select_r)
         3'h0: wake = FEEDBACK < wake_level_r;
         3'h1: wake = FEEDBACK > wake_level_r;
         3'h2: wake = !err_diff[16] && err_diff[15:0] > wake_level_r;
         default: wake = 1'b0;
      endcase
   end

   // Start delay timer
   prs_hold_timer u_fail_timer
   (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .tick(tick),
      .cond(state_r == PRS_PREREG && fb_low && prereg_fail_delay_r != 16'h0000),
      .limit(prereg_fail_delay_r),
      .expired(fail_exp)
   );

   // Sleep delay timer
   prs_hold_timer u_sleep_timer
   (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .tick(tick),
      .cond(state_r == PRS_PID && low_freq),
      .limit(sleep_delay_time_r),
      .expired(sleep_exp)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         PRS_IDLE:
            if (run)
               state_nxt = ctrl_r[`PRS_CTRL_PREREG_EN_BIT] ? PRS_PREREG : PRS_PID;
         PRS_PREREG:
            if (!run)
               state_nxt = PRS_IDLE;
            else if (fail_exp)
               state_nxt = PRS_FAULT;
            else if (!fb_low)
               state_nxt = PRS_PID;
         PRS_PID:
            if (!run)
               state_nxt = PRS_IDLE;
            else if (bypass)
               state_nxt = PRS_OPEN;
            else if (sleep_exp)
               state_nxt = PRS_SLEEP;
         PRS_OPEN:
            if (!run)
               state_nxt = PRS_IDLE;
            else if (!bypass)
               state_nxt = PRS_PID;
         PRS_SLEEP:
            if (!run)
               state_nxt = PRS_IDLE;
            else if (wake)
               state_nxt = PRS_PID;
         PRS_FAULT:
            if (ctrl_r[`PRS_CTRL_FAULT_CLR_BIT])
               state_nxt = PRS_IDLE;
         default: state_nxt = PRS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
         state_r <= PRS_IDLE;
      else
         state_r <= state_nxt;
   end

   // Outputs follow the next state
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         FREQ_TARGET <= 16'h0000;
         PID_ACTIVE <= 1'b0;
         OUTPUT_ENABLE <= 1'b0;
         STARTUP_FEEDBACK_FAULT <= 1'b0;
         SLEEPING <= 1'b0;
      end
      else
      begin
         FREQ_TARGET <= (state_nxt == PRS_PREREG) ? prereg_frequency_r : 16'h0000;
         PID_ACTIVE <= (state_nxt == PRS_PID);
         OUTPUT_ENABLE <= (state_nxt == PRS_PREREG || state_nxt == PRS_PID || state_nxt == PRS_OPEN);
         STARTUP_FEEDBACK_FAULT <= (state_nxt == PRS_FAULT);
         SLEEPING <= (state_nxt == PRS_SLEEP);
      end
   end

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   assign irq_set = {(state_r == PRS_SLEEP && state_nxt == PRS_PID),
                     (state_r != PRS_SLEEP && state_nxt == PRS_SLEEP),
                     (state_r != PRS_FAULT && state_nxt == PRS_FAULT)};

   // Sticky status, set wins over clear
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         irq_stat_r <= '0;
         IRQ <= 1'b0;
      end
      else
      begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
         IRQ <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
      end
   end
endmodule

// ---- testbench/prs_asserts.sv ----
// Port-level assertions for the run sequencer
`timescale 1ns/100ps
`include "prs_map.svh"
module prs_asserts
(
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   // Register write channels
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // Process side
   input wire logic [4:0] MFI_ACTIVE,
   input wire logic [39:0] MFI_FUNC,
   input wire prs_pkg::prs_word_t FEEDBACK,
   input wire prs_pkg::prs_word_t REFERENCE,
   input wire prs_pkg::prs_word_t FREQ_TARGET,
   input wire logic PID_ACTIVE,
   input wire logic OUTPUT_ENABLE,
   input wire logic STARTUP_FEEDBACK_FAULT,
   input wire logic SLEEPING
);
   import prs_pkg::*;
   logic [7:0] aw_r;
   logic [15:0] w_r, exit_r, wl_r;
   logic [2:0] sel_r;
   logic run_r, byp, wake_ok, prereg;
   logic aw_h, w_h;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   // Shadow copies of the registers written over the bus
   always_ff @(posedge CLK_SYS or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         aw_r <= 8'h00;
         w_r <= 16'h0000;
         exit_r <= 16'h0000;
         wl_r <= 16'h0000;
         sel_r <= 3'h0;
         run_r <= 1'b0;
         aw_h <= 1'b0;
         w_h <= 1'b0;
      end
      else
      begin
         if (S_AXI_AWVALID && S_AXI_AWREADY)
         begin
            aw_r <= S_AXI_AWADDR;
            aw_h <= 1'b1;
         end
         if (S_AXI_WVALID && S_AXI_WREADY)
         begin
            w_r <= S_AXI_WDATA[15:0];
            w_h <= 1'b1;
         end
         // Applied on the edge at which the slave commits the write
         if (aw_h && w_h && !S_AXI_BVALID)
         begin
            aw_h <= 1'b0;
            w_h <= 1'b0;
            case (aw_r)
               `PRS_CTRL_OFS: run_r <= w_r[`PRS_CTRL_RUN_BIT];
               `PRS_PREREG_EXIT_OFS: exit_r <= w_r;
               `PRS_WAKE_LEVEL_OFS: wl_r <= w_r;
               `PRS_WAKE_SEL_OFS: sel_r <= w_r[2:0];
               default: ;
            endcase
         end
      end
   end
   // Bypass request, wake test, pre-regulation view
   always_comb
   begin
      byp = 1'b0;
      for (int i = 0; i < 5; i++)
         byp |= MFI_ACTIVE[i] && MFI_FUNC[8*i +: 8] == `PRS_BYPASS_FUNC_CODE;
      case (sel_r)
         3'h0: wake_ok = FEEDBACK < wl_r;
         3'h1: wake_ok = FEEDBACK > wl_r;
         3'h2: wake_ok = int'(REFERENCE) - int'(FEEDBACK) > int'(wl_r);
         default: wake_ok = 1'b0;
      endcase
      prereg = FREQ_TARGET != 16'h0000;
   end
   a_prereg_out: assert property (prereg |-> OUTPUT_ENABLE && !PID_ACTIVE)
      else $error("pre-regulation output wrong");
   a_prereg_exit: assert property (prereg && run_r && FEEDBACK > exit_r |-> ##[1:5] PID_ACTIVE)
      else $error("no hand-over after exit level");
   a_fault_block: assert property (STARTUP_FEEDBACK_FAULT |-> !OUTPUT_ENABLE)
      else $error("output live during fault");
   a_sleep_entry: assert property ($rose(SLEEPING) |-> $past(PID_ACTIVE))
      else $error("sleep entered outside regulation");
   a_sleep_stop: assert property (SLEEPING |-> !OUTPUT_ENABLE && !PID_ACTIVE)
      else $error("output live in sleep");
   a_wake_cause: assert property ($fell(SLEEPING) |-> $past(wake_ok) || $past(wake_ok, 2) || !run_r)
      else $error("wake without its condition");
   a_wake_reserved: assert property ((SLEEPING && run_r && sel_r > 3'h2) [*3] |=> SLEEPING)
      else $error("reserved wake mode left sleep");
   a_bypass_halt: assert property (byp [*6] |-> !PID_ACTIVE)
      else $error("regulation during bypass");
   a_bypass_resume: assert property ($fell(byp) && OUTPUT_ENABLE && !PID_ACTIVE && !prereg && run_r
      |-> ##[1:4] PID_ACTIVE)
      else $error("regulation not resumed");
   a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   c_sleep: cover property ($rose(SLEEPING));
   c_wake: cover property ($fell(SLEEPING));
   c_open: cover property (byp && OUTPUT_ENABLE && !PID_ACTIVE);
endmodule

bind prs_top prs_asserts u_chk
(
   .CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
   .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .MFI_ACTIVE(MFI_ACTIVE), .MFI_FUNC(MFI_FUNC), .FEEDBACK(FEEDBACK), .REFERENCE(REFERENCE),
   .FREQ_TARGET(FREQ_TARGET), .PID_ACTIVE(PID_ACTIVE), .OUTPUT_ENABLE(OUTPUT_ENABLE),
   .STARTUP_FEEDBACK_FAULT(STARTUP_FEEDBACK_FAULT), .SLEEPING(SLEEPING)
);

// ---- testbench/prs_stage_model.sv ----
// Motor output stage model driving the measured frequency
`timescale 1ns/100ps
module prs_stage_model
(
   // Clock
   input wire logic clk,
   // From the sequencer
   input wire logic out_en,
   // Bench controls
   input wire logic slow,
   input wire prs_pkg::prs_word_t speed,
   // To the sequencer
   output prs_pkg::prs_word_t out_freq
);
   import prs_pkg::*;
   // Speed follows the command only while driven, ramping when slow
   always_ff @(posedge clk)
   begin
      if (!out_en)
         out_freq <= 16'h0000;
      else if (!slow || out_freq >= speed)
         out_freq <= speed;
      else
         out_freq <= out_freq + 16'h0001;
   end
endmodule

// ---- testbench/prs_top_tb.sv ----
// Self-checking bench for the run sequencer
`timescale 1ns/100ps
`include "prs_map.svh"
module prs_top_tb;
   import prs_pkg::*;
   logic CLK_SYS = 1'b0;
   logic ARST_N = 1'b0;
   logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
   logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, slow = 1'b0;
   logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
   logic [3:0] S_AXI_WSTRB = 4'hf;
   logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic PID_ACTIVE, OUTPUT_ENABLE, STARTUP_FEEDBACK_FAULT, SLEEPING, IRQ;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rsp;
   logic [4:0] MFI_ACTIVE = 5'h00;
   logic [39:0] MFI_FUNC = 40'h0, f;
   prs_word_t FEEDBACK = 16'h0000, REFERENCE = 16'h0bb8, spd = 16'h0000, OUT_FREQ, FREQ_TARGET;
   int failures = 0, num_checks = 0, cyc = 0, seed = 32'h4be41b14;
   int pf, k, w, m, m_state;
   int modes[5] = '{0, 1, 2, 3, 7};

   prs_top dut (.*);
   prs_stage_model u_motor (.clk(CLK_SYS), .out_en(OUTPUT_ENABLE), .slow(slow), .speed(spd), .out_freq(OUT_FREQ));

   always #2 CLK_SYS = ~CLK_SYS;
   // Hang guard
   always @(posedge CLK_SYS)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         failures++;
         conclude();
      end
   end
   // ---------------------------------
   // Bus tasks, model and comparison
   // ---------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      do
      begin
         @(posedge CLK_SYS);
         if (S_AXI_AWREADY)
            S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY)
            S_AXI_WVALID <= 1'b0;
      end while (!S_AXI_BVALID);
      rsp = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge CLK_SYS);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do
      begin
         @(posedge CLK_SYS);
         if (S_AXI_ARREADY)
            S_AXI_ARVALID <= 1'b0;
      end while (!S_AXI_RVALID);
      rd = S_AXI_RDATA;
      rsp = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
   endtask
   // Outputs follow from the modelled state code
   task automatic expect_state(input int s);
      m_state = s;
      repeat (6) @(posedge CLK_SYS);
      rdr(`PRS_STATUS_OFS);
      chk("status", m_state, rd);
      chk("pid_active", m_state == 2, PID_ACTIVE);
      chk("output_enable", m_state inside {1, 2, 3}, OUTPUT_ENABLE);
      chk("sleeping", m_state == 4, SLEEPING);
      chk("startup_fault", m_state == 5, STARTUP_FEEDBACK_FAULT);
      chk("freq_target", m_state == 1 ? pf : 0, FREQ_TARGET);
   endtask
   // Expected state after a feedback step while asleep
   function automatic int wake_exp(int md, int fb, int rf, int wl);
      if (md == 0)
         return (fb < wl) ? 2 : 4;
      if (md == 1)
         return (fb > wl) ? 2 : 4;
      if (md == 2)
         return (rf - fb > wl) ? 2 : 4;
      return 4;
   endfunction
   // Feedback just on either side of each wake condition
   function automatic int fbv(int md, int wl, bit yes);
      if (md == 1)
         return yes ? wl + 5 : wl - 5;
      if (md == 2)
         return 3000 - wl - yes;
      return (md == 0 && !yes) ? wl + 5 : wl - 5;
   endfunction
   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ---------------------------------
   // Main sequence
   // ---------------------------------
   initial
   begin
      repeat (3) @(posedge CLK_SYS);
      ARST_N <= 1'b1;
      rdr(`PRS_STATUS_OFS);
      chk("status_rst", 0, rd);
      rdr(8'h30);
      chk("unmapped_resp", 2, rsp);
      wr(`PRS_STATUS_OFS, 32'h5);
      chk("ro_resp", 2, rsp);
      pf = 1 + $unsigned($random(seed)) % 4095;
      wr(`PRS_PREREG_FREQ_OFS, pf);
      wr(`PRS_PREREG_EXIT_OFS, 32'h400);
      FEEDBACK <= 16'h0100;
      spd <= 16'h0800;
      slow <= 1'b1;
      wr(`PRS_CTRL_OFS, 32'h3);
      expect_state(1);
      FEEDBACK <= 16'h0400;
      expect_state(1);
      FEEDBACK <= 16'h0401;
      expect_state(2);
      slow <= 1'b0;
      k = $unsigned($random(seed)) % 5;
      f = {5{8'h16}};
      f[8*k +: 8] = `PRS_BYPASS_FUNC_CODE;
      MFI_FUNC <= f;
      MFI_ACTIVE <= 5'h1f & ~(5'h01 << k);
      expect_state(2);
      MFI_ACTIVE <= 5'h1f;
      expect_state(3);
      MFI_ACTIVE <= 5'h00;
      expect_state(2);
      wr(`PRS_IRQ_EN_OFS, 32'h2);
      for (int i = 0; i < 5; i++)
      begin
         m = modes[i];
         w = 100 + $unsigned($random(seed)) % 900;
         wr(`PRS_WAKE_SEL_OFS, m);
         wr(`PRS_WAKE_LEVEL_OFS, w);
         FEEDBACK <= fbv(m, w, 0);
         wr(`PRS_SLEEP_FREQ_OFS, 32'h200);
         spd <= 16'h0200;
         expect_state(2);
         spd <= 16'h01ff;
         expect_state(4);
         chk("irq_sleep", 1, IRQ);
         wr(`PRS_IRQ_CLR_OFS, 32'h7);
         wr(`PRS_SLEEP_FREQ_OFS, 32'h0);
         spd <= 16'h0800;
         expect_state(4);
         FEEDBACK <= fbv(m, w, 1);
         expect_state(wake_exp(m, fbv(m, w, 1), 3000, w));
         chk("irq_masked", 0, IRQ);
         wr(`PRS_WAKE_SEL_OFS, 0);
         FEEDBACK <= 16'h0000;
         expect_state(2);
      end
      conclude();
   end
endmodule
